// ==== src/ssfd_map.vh ====
`ifndef SSFD_MAP_VH
`define SSFD_MAP_VH

// Register offsets
`define SSFD_ADDR_SYSREF_CTRL 16'h0120
`define SSFD_ADDR_IGNORE_COUNT 16'h0121
`define SSFD_ADDR_TS_DELAY 16'h0123
`define SSFD_ADDR_SETUP_HOLD 16'h0128
`define SSFD_ADDR_DIV_PHASE 16'h0129
`define SSFD_ADDR_CAPTURE_COUNT 16'h012A
`define SSFD_ADDR_SYNC_MODE 16'h01FF
`define SSFD_ADDR_APP_MODE 16'h0200
`define SSFD_ADDR_DECIMATION 16'h0201
`define SSFD_ADDR_OFFSET 16'h0228
`define SSFD_ADDR_FLAG_CTRL 16'h0245
`define SSFD_ADDR_UPPER_LOW 16'h0247
`define SSFD_ADDR_UPPER_HIGH 16'h0248
`define SSFD_ADDR_LOWER_LOW 16'h0249
`define SSFD_ADDR_LOWER_HIGH 16'h024A
`define SSFD_ADDR_DWELL_LOW 16'h024B
`define SSFD_ADDR_DWELL_HIGH 16'h024C
`define SSFD_ADDR_MON_SYNC 16'h026F
`define SSFD_ADDR_MON_PEAK 16'h0270

// Field positions
`define SSFD_BIT_FLAG_RESET        6
`define SSFD_BIT_TRANSITION        4
`define SSFD_BIT_CLK_EDGE          3
`define SSFD_BIT_QIGNORE           5
`define SSFD_BIT_FORCE             3
`define SSFD_BIT_FORCE_VAL         2
`define SSFD_BIT_FLAG_EN           0
`define SSFD_BIT_MON_SYNC          0
`define SSFD_BIT_PEAK_EN           1

// Mode encodings
`define SSFD_CAP_DISABLED          2'h0
`define SSFD_CAP_CONTINUOUS        2'h1
`define SSFD_CAP_NSHOT             2'h2

// Reset values
`define SSFD_RST_TS_DELAY          7'h40
`define SSFD_RST_APP_MODE          4'h7
`define SSFD_RST_ZERO8             8'h00

`endif

// ==== src/ssfd_regs.v ====
// Function
// RULE1 - N-shot skips ignore-count transitions, then uses one
// RULE2 - Timestamp delayed by 7-bit count, reset 0x40
// RULE3 - Hold status high nibble, setup low nibble
// RULE4 - Divider phase recorded at SYSREF capture
// RULE5 - 8-bit capture counter increments and wraps
// RULE6 - Flag-reset bit clears capture counter
// RULE7 - Host reads counter only with capture disabled
// RULE8 - Sync mode 0: reset dividers, phase change interrupts link
// RULE9 - Sync mode 1: only timestamp the passing sample
// RULE10 - Quadrature-ignore bit selects real-only output
// RULE11 - Application mode field, reset value 0x7
// RULE12 - Decimation codes 000..100 select 1..16
// RULE13 - Signed offset -128..+127 added to datapath
// RULE14 - Force bit drives pin with force value
// RULE15 - Bit 0 enables fine fast-detect output
// RULE16 - Magnitude compared with 13-bit upper threshold
// RULE17 - Magnitude compared with 13-bit lower threshold
// RULE18 - Dwell counter below lower threshold clears pin
// RULE19 - Monitor sync on next SYSREF, then self-clears
// RULE20 - Host enables SYSREF capture before monitor sync
// RULE21 - Bit 1 enables the peak detector
// RULE22 - Capture mode select; polarity change needs disabled
// RULE23 - Flag-reset holds setup/hold flags cleared
// RULE24 - Pin sets above upper, holds until dwell done
// RULE25 - Reserved bits read zero, fields read back
`timescale 1ns/1ns
`include "ssfd_map.vh"

module ssfd_regs (
    clk,
    rst_b,
    reg_addr,
    reg_wdata,
    reg_wr,
    reg_rd,
    reg_rdata,
    sysref_in,
    div_phase_in,
    setup_win_in,
    hold_win_in,
    fine_mag,
    sample_in,
    sample_out,
    level_flag_pin,
    divider_reset,
    link_interrupt,
    timestamp_mark,
    monitor_sync,
    app_mode,
    decim_factor,
    q_ignore,
    peak_detect_en,
    capture_edge_fall
);
    input  wire        clk;
    input  wire        rst_b;
    input  wire [15:0] reg_addr;
    input  wire [7:0]  reg_wdata;
    input  wire        reg_wr;
    input  wire        reg_rd;
    output reg  [7:0]  reg_rdata;
    input  wire        sysref_in;
    input  wire [3:0]  div_phase_in;
    input  wire [3:0]  setup_win_in;
    input  wire [3:0]  hold_win_in;
    input  wire [12:0] fine_mag;
    input  wire [13:0] sample_in;
    output reg  [13:0] sample_out;
    output wire        level_flag_pin;
    output reg         divider_reset;
    output reg         link_interrupt;
    output reg         timestamp_mark;
    output reg         monitor_sync;
    output wire [3:0]  app_mode;
    output wire [4:0]  decim_factor;
    output wire        q_ignore;
    output wire        peak_detect_en;
    output wire        capture_edge_fall;

    reg  [7:0]  sysref_ctrl_reg;
    reg  [3:0]  ignore_count_reg;
    reg  [6:0]  ts_delay_reg;
    reg  [7:0]  setup_hold_reg;
    reg  [3:0]  div_phase_reg;
    reg  [7:0]  capture_count_reg;
    reg         sync_mode_reg;
    reg         q_ignore_reg;
    reg  [3:0]  app_mode_reg;
    reg  [2:0]  decim_reg;
    reg  [7:0]  offset_reg;
    reg  [3:0]  flag_ctrl_reg;
    reg  [7:0]  upper_low_reg;
    reg  [4:0]  upper_high_reg;
    reg  [7:0]  lower_low_reg;
    reg  [4:0]  lower_high_reg;
    reg  [7:0]  dwell_low_reg;
    reg  [7:0]  dwell_high_reg;
    reg         mon_sync_reg;
    reg         peak_en_reg;

    reg         sysref_prev_reg;
    reg  [3:0]  skip_left_reg;
    reg         nshot_armed_reg;
    reg  [6:0]  ts_cnt_reg;
    reg         ts_busy_reg;
    reg         flag_state_reg;
    reg  [15:0] dwell_cnt_reg;
    reg  [7:0]  rdata_next;

    wire [1:0]  cap_mode;
    wire        flag_reset;
    wire        sysref_edge;
    wire        edge_ok;
    wire        capture;
    wire [12:0] upper_thresh;
    wire [12:0] lower_thresh;
    wire        wr_ctrl;
    wire        wr_ignore;

    // Joins a 5-bit high field and a low byte into a threshold
    function [12:0] join_thresh;
        input [4:0] high;
        input [7:0] low;
        begin
            join_thresh = {high, low};
        end
    endfunction

    // Decimation code to factor; undefined codes fall back to 1
    function [4:0] decim_of;
        input [2:0] code;
        begin
            case (code)
                3'h0:    decim_of = 5'h01;
                3'h1:    decim_of = 5'h02;
                3'h2:    decim_of = 5'h04;
                3'h3:    decim_of = 5'h08;
                3'h4:    decim_of = 5'h10;
                default: decim_of = 5'h01;
            endcase
        end
    endfunction

    assign cap_mode   = sysref_ctrl_reg[2:1];
    assign flag_reset = sysref_ctrl_reg[`SSFD_BIT_FLAG_RESET];
    assign wr_ctrl    = reg_wr && (reg_addr == `SSFD_ADDR_SYSREF_CTRL);
    assign wr_ignore  = reg_wr && (reg_addr == `SSFD_ADDR_IGNORE_COUNT);

    // Transition select picks rising or falling SYSREF edges
    assign sysref_edge = sysref_ctrl_reg[`SSFD_BIT_TRANSITION] ?
                         (sysref_prev_reg && !sysref_in) :
                         (!sysref_prev_reg && sysref_in);

    assign edge_ok = sysref_edge && (cap_mode != `SSFD_CAP_DISABLED); // RULE22

    // N-shot uses one edge after the skip count is spent
    assign capture = edge_ok &&
                     ((cap_mode == `SSFD_CAP_CONTINUOUS) ||
                      ((cap_mode == `SSFD_CAP_NSHOT) && nshot_armed_reg &&
                       (skip_left_reg == 4'h0))); // RULE1

    assign upper_thresh = join_thresh(upper_high_reg, upper_low_reg); // RULE16
    assign lower_thresh = join_thresh(lower_high_reg, lower_low_reg); // RULE17

    assign app_mode          = app_mode_reg; // RULE11
    assign decim_factor      = decim_of(decim_reg); // RULE12
    assign q_ignore          = q_ignore_reg; // RULE10
    assign peak_detect_en    = peak_en_reg; // RULE21
    assign capture_edge_fall = sysref_ctrl_reg[`SSFD_BIT_CLK_EDGE];

    assign level_flag_pin = flag_ctrl_reg[`SSFD_BIT_FORCE] ?
                            flag_ctrl_reg[`SSFD_BIT_FORCE_VAL] : // RULE14
                            (flag_ctrl_reg[`SSFD_BIT_FLAG_EN] &&
                             flag_state_reg); // RULE15

    // Host writes; hardware self-clear of monitor sync loses to a write
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sysref_ctrl_reg  <= `SSFD_RST_ZERO8;
            ignore_count_reg <= 4'h0;
            ts_delay_reg     <= `SSFD_RST_TS_DELAY; // RULE2
            sync_mode_reg    <= 1'b0;
            q_ignore_reg     <= 1'b0;
            app_mode_reg     <= `SSFD_RST_APP_MODE; // RULE11
            decim_reg        <= 3'h0;
            offset_reg       <= `SSFD_RST_ZERO8;
            flag_ctrl_reg    <= 4'h0;
            upper_low_reg    <= `SSFD_RST_ZERO8;
            upper_high_reg   <= 5'h00;
            lower_low_reg    <= `SSFD_RST_ZERO8;
            lower_high_reg   <= 5'h00;
            dwell_low_reg    <= `SSFD_RST_ZERO8;
            dwell_high_reg   <= `SSFD_RST_ZERO8;
            mon_sync_reg     <= 1'b0;
            peak_en_reg      <= 1'b0;
        end else begin
            if (capture && mon_sync_reg) begin
                mon_sync_reg <= 1'b0; // RULE19
            end
            if (reg_wr) begin
                case (reg_addr)
                    `SSFD_ADDR_SYSREF_CTRL: begin
                        sysref_ctrl_reg[6] <= reg_wdata[6];
                        sysref_ctrl_reg[3:1] <= reg_wdata[3:1];
                        // Polarity only moves while capture is off
                        if (cap_mode == `SSFD_CAP_DISABLED) begin
                            sysref_ctrl_reg[4] <= reg_wdata[4]; // RULE22
                        end
                    end
                    `SSFD_ADDR_IGNORE_COUNT:
                        ignore_count_reg <= reg_wdata[3:0];
                    `SSFD_ADDR_TS_DELAY:
                        ts_delay_reg <= reg_wdata[6:0];
                    `SSFD_ADDR_SYNC_MODE:
                        sync_mode_reg <= reg_wdata[0];
                    `SSFD_ADDR_APP_MODE: begin
                        q_ignore_reg <= reg_wdata[`SSFD_BIT_QIGNORE];
                        app_mode_reg <= reg_wdata[3:0];
                    end
                    `SSFD_ADDR_DECIMATION:
                        decim_reg <= reg_wdata[2:0];
                    `SSFD_ADDR_OFFSET:
                        offset_reg <= reg_wdata;
                    `SSFD_ADDR_FLAG_CTRL:
                        flag_ctrl_reg <= {reg_wdata[3:2], 1'b0, reg_wdata[0]};
                    `SSFD_ADDR_UPPER_LOW:
                        upper_low_reg <= reg_wdata;
                    `SSFD_ADDR_UPPER_HIGH:
                        upper_high_reg <= reg_wdata[4:0];
                    `SSFD_ADDR_LOWER_LOW:
                        lower_low_reg <= reg_wdata;
                    `SSFD_ADDR_LOWER_HIGH:
                        lower_high_reg <= reg_wdata[4:0];
                    `SSFD_ADDR_DWELL_LOW:
                        dwell_low_reg <= reg_wdata;
                    `SSFD_ADDR_DWELL_HIGH:
                        dwell_high_reg <= reg_wdata;
                    `SSFD_ADDR_MON_SYNC:
                        mon_sync_reg <= reg_wdata[`SSFD_BIT_MON_SYNC];
                    `SSFD_ADDR_MON_PEAK:
                        peak_en_reg <= reg_wdata[`SSFD_BIT_PEAK_EN];
                    default: begin
                    end
                endcase
            end
        end
    end

    // N-shot arming: a write to control or ignore count re-arms it
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sysref_prev_reg <= 1'b0;
            skip_left_reg   <= 4'h0;
            nshot_armed_reg <= 1'b0;
        end else begin
            sysref_prev_reg <= sysref_in;
            if (wr_ctrl || wr_ignore) begin
                skip_left_reg   <= wr_ignore ? reg_wdata[3:0] :
                                   ignore_count_reg;
                nshot_armed_reg <= 1'b1;
            end else if (edge_ok && cap_mode == `SSFD_CAP_NSHOT &&
                         nshot_armed_reg) begin
                if (skip_left_reg != 4'h0) begin
                    skip_left_reg <= skip_left_reg - 4'h1; // RULE1
                end else begin
                    nshot_armed_reg <= 1'b0;
                end
            end
        end
    end

    // Capture status, counter and sync actions
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            setup_hold_reg    <= `SSFD_RST_ZERO8;
            div_phase_reg     <= 4'h0;
            capture_count_reg <= `SSFD_RST_ZERO8;
            divider_reset     <= 1'b0;
            link_interrupt    <= 1'b0;
            monitor_sync      <= 1'b0;
        end else begin
            divider_reset  <= capture && !sync_mode_reg; // RULE8
            // Non-zero phase means the dividers must jump
            link_interrupt <= capture && !sync_mode_reg &&
                              (div_phase_in != 4'h0); // RULE8
            monitor_sync   <= capture && mon_sync_reg; // RULE19
            if (capture) begin
                div_phase_reg <= div_phase_in; // RULE4
            end
            // Held clear dominates a capture in the same cycle
            if (flag_reset) begin
                setup_hold_reg <= `SSFD_RST_ZERO8; // RULE23
            end else if (capture) begin
                setup_hold_reg <= {hold_win_in, setup_win_in}; // RULE3
            end
            if (flag_reset) begin
                capture_count_reg <= `SSFD_RST_ZERO8; // RULE6
            end else if (capture) begin
                capture_count_reg <= capture_count_reg + 8'h01; // RULE5
            end
        end
    end

    // Timestamp mark, only in timestamp sync mode; a new capture restarts
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ts_cnt_reg     <= 7'h00;
            ts_busy_reg    <= 1'b0;
            timestamp_mark <= 1'b0;
        end else begin
            timestamp_mark <= 1'b0;
            if (capture && sync_mode_reg) begin
                ts_cnt_reg  <= ts_delay_reg; // RULE2
                ts_busy_reg <= 1'b1; // RULE9
            end else if (ts_busy_reg) begin
                if (ts_cnt_reg == 7'h00) begin
                    timestamp_mark <= 1'b1;
                    ts_busy_reg    <= 1'b0;
                end else begin
                    ts_cnt_reg <= ts_cnt_reg - 7'h01;
                end
            end
        end
    end

    // Fast detect with dwell hysteresis
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            flag_state_reg <= 1'b0;
            dwell_cnt_reg  <= 16'h0000;
        end else begin
            if (fine_mag > upper_thresh) begin
                flag_state_reg <= 1'b1; // RULE24
                dwell_cnt_reg  <= {dwell_high_reg, dwell_low_reg}; // RULE18
            end else if (flag_state_reg) begin
                if (fine_mag < lower_thresh) begin
                    if (dwell_cnt_reg == 16'h0000) begin
                        flag_state_reg <= 1'b0; // RULE18
                    end else begin
                        dwell_cnt_reg <= dwell_cnt_reg - 16'h0001;
                    end
                end else begin
                    dwell_cnt_reg <= {dwell_high_reg, dwell_low_reg};
                end
            end
        end
    end

    // Offset add with saturation so a wrap cannot flip the sign
    always @(posedge clk or negedge rst_b) begin : offset_add
        reg [14:0] sum;
        if (!rst_b) begin
            sample_out <= 14'h0000;
        end else begin
            sum = {sample_in[13], sample_in} +
                  {{7{offset_reg[7]}}, offset_reg}; // RULE13
            if (sum[14] != sum[13]) begin
                sample_out <= sum[14] ? 14'h2000 : 14'h1FFF;
            end else begin
                sample_out <= sum[13:0];
            end
        end
    end

    // Read mux; reserved bits and unmapped offsets read zero
    always @* begin
        case (reg_addr)
            `SSFD_ADDR_SYSREF_CTRL:
                rdata_next = {1'b0, sysref_ctrl_reg[6], 1'b0,
                              sysref_ctrl_reg[4:1], 1'b0};
            `SSFD_ADDR_IGNORE_COUNT: rdata_next = {4'h0, ignore_count_reg};
            `SSFD_ADDR_TS_DELAY:     rdata_next = {1'b0, ts_delay_reg};
            `SSFD_ADDR_SETUP_HOLD:   rdata_next = setup_hold_reg; // RULE3
            `SSFD_ADDR_DIV_PHASE:    rdata_next = {4'h0, div_phase_reg};
            // Only coherent with capture disabled
            `SSFD_ADDR_CAPTURE_COUNT: rdata_next = capture_count_reg; // RULE7
            `SSFD_ADDR_SYNC_MODE:    rdata_next = {7'h00, sync_mode_reg};
            `SSFD_ADDR_APP_MODE:
                rdata_next = {2'h0, q_ignore_reg, 1'b0, app_mode_reg};
            `SSFD_ADDR_DECIMATION:   rdata_next = {5'h00, decim_reg};
            `SSFD_ADDR_OFFSET:       rdata_next = offset_reg;
            `SSFD_ADDR_FLAG_CTRL:    rdata_next = {4'h0, flag_ctrl_reg};
            `SSFD_ADDR_UPPER_LOW:    rdata_next = upper_low_reg;
            `SSFD_ADDR_UPPER_HIGH:   rdata_next = {3'h0, upper_high_reg};
            `SSFD_ADDR_LOWER_LOW:    rdata_next = lower_low_reg;
            `SSFD_ADDR_LOWER_HIGH:   rdata_next = {3'h0, lower_high_reg};
            `SSFD_ADDR_DWELL_LOW:    rdata_next = dwell_low_reg;
            `SSFD_ADDR_DWELL_HIGH:   rdata_next = dwell_high_reg;
            `SSFD_ADDR_MON_SYNC:     rdata_next = {7'h00, mon_sync_reg};
            `SSFD_ADDR_MON_PEAK:     rdata_next = {6'h00, peak_en_reg, 1'b0};
            default:                 rdata_next = 8'h00; // RULE25
        endcase
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rdata_next; // RULE25
        end
    end

endmodule

// ==== bench/ssfd_regs_properties.sv ====
`timescale 1ns/1ns
`include "ssfd_map.vh"

module ssfd_regs_chk (
    input wire        clk,
    input wire        rst_b,
    input wire [15:0] reg_addr,
    input wire [7:0]  reg_wdata,
    input wire        reg_wr,
    input wire        reg_rd,
    input wire [7:0]  reg_rdata,
    input wire        sysref_in,
    input wire [3:0]  div_phase_in,
    input wire        level_flag_pin,
    input wire        divider_reset,
    input wire        link_interrupt,
    input wire        timestamp_mark,
    input wire        monitor_sync,
    input wire [3:0]  app_mode,
    input wire [4:0]  decim_factor,
    input wire        q_ignore,
    input wire        peak_detect_en
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    reset_outs_a: assert property (
        $rose(rst_b) |-> app_mode == 4'h7 && decim_factor == 5'h01
        && !peak_detect_en) else $error("outputs off reset value");
    rdata_hold_a: assert property (
        !reg_rd |=> $stable(reg_rdata)) else $error("read data moved");
    div_reset_edge_a: assert property (
        divider_reset |-> $past(sysref_in) != $past(sysref_in, 2))
        else $error("divider reset without edge");
    div_reset_pulse_a: assert property (
        divider_reset |=> !divider_reset) else $error("long reset pulse");
    link_cause_a: assert property (
        link_interrupt |-> divider_reset && $past(div_phase_in) != 4'h0)
        else $error("link interrupt without phase change");
    ts_pulse_a: assert property (
        timestamp_mark |=> !timestamp_mark) else $error("long mark");
    mon_sync_edge_a: assert property (
        monitor_sync |-> $past(sysref_in) != $past(sysref_in, 2)
        ##1 !monitor_sync) else $error("monitor sync misplaced");
    app_write_a: assert property (
        reg_wr && reg_addr == `SSFD_ADDR_APP_MODE |=>
        {4'h0, app_mode} == ($past(reg_wdata) & 8'h0F)
        && {2'h0, q_ignore, 5'h00} == ($past(reg_wdata) & 8'h20))
        else $error("mode outputs not from write");
    decim_write_a: assert property (
        reg_wr && reg_addr == `SSFD_ADDR_DECIMATION && reg_wdata < 8'h05
        |=> decim_factor == (5'h01 << ($past(reg_wdata) & 8'h07)))
        else $error("decimation factor wrong");
    decim_legal_a: assert property (
        $onehot(decim_factor)) else $error("decimation not a power");
    peak_write_a: assert property (
        reg_wr && reg_addr == `SSFD_ADDR_MON_PEAK |=>
        peak_detect_en == (($past(reg_wdata) & 8'h02) != 8'h00))
        else $error("peak enable not from write");

    cover property (divider_reset);
    cover property (link_interrupt);
    cover property (timestamp_mark);
    cover property ($rose(level_flag_pin));
endmodule

bind ssfd_regs ssfd_regs_chk ssfd_regs_chk_inst (.*);

// ==== bench/ssfd_sysref_src.sv ====
`timescale 1ns/1ns

// Timing source: n pulses, two cycles high, two low, idle low
module ssfd_sysref_src (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       req,
    input  wire logic [9:0] num,
    output wire logic       sysref,
    output wire logic       busy
);
    logic [9:0] left_reg;
    logic [1:0] ph_reg;
    logic       sysref_reg;

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            left_reg <= 10'h000;
            ph_reg <= 2'h0;
            sysref_reg <= 1'b0;
        end else if (req) begin
            left_reg <= num;
            ph_reg <= 2'h0;
        end else if (left_reg != 10'h000) begin
            ph_reg <= ph_reg + 2'h1;
            sysref_reg <= (ph_reg < 2'h2);
            if (ph_reg == 2'h3)
                left_reg <= left_reg - 10'h001;
        end
    end
    assign sysref = sysref_reg;
    assign busy = (left_reg != 10'h000);
endmodule

// ==== bench/ssfd_regs_bench.sv ====
`timescale 1ns/1ns
`include "ssfd_map.vh"

module ssfd_regs_bench;
    logic        clk, rst_b, reg_wr, reg_rd, sysref_in, req, busy;
    logic [15:0] reg_addr;
    logic [7:0]  reg_wdata, reg_rdata;
    logic [3:0]  div_phase_in, setup_win_in, hold_win_in, app_mode;
    logic [12:0] fine_mag;
    logic [13:0] sample_in, sample_out;
    logic        level_flag_pin, divider_reset, link_interrupt;
    logic        timestamp_mark, monitor_sync, q_ignore, peak_detect_en;
    logic [4:0]  decim_factor;
    logic [9:0]  num;
    logic        sr_prev, capture_edge_fall;
    int          num_errors, samples_checked, cyc, e_cyc, ts_cyc;
    int          dr_n, li_n, ms_n, i, j;
    // Address, reset value, write value, read-back value
    localparam logic [39:0] TBL [0:17] = '{
        40'h0121_00_FF_0F, 40'h0123_40_FF_7F, 40'h0128_00_FF_00,
        40'h0129_00_FF_00, 40'h012A_00_FF_00, 40'h01FF_00_FF_01,
        40'h0200_07_2F_2F, 40'h0201_00_FF_07, 40'h0228_00_FF_FF,
        40'h0245_00_FF_0D, 40'h0247_00_FF_FF, 40'h0248_00_FF_1F,
        40'h0249_00_FF_FF, 40'h024A_00_FF_1F, 40'h024B_00_FF_FF,
        40'h024C_00_FF_FF, 40'h0270_00_FF_02, 40'h0122_00_FF_00};
    localparam logic [19:0] MODES = 20'h87210;
    localparam logic [15:0] TWO_D = 16'h7F00;

    ssfd_regs ssfd_regs_inst (.*);
    ssfd_sysref_src ssfd_sysref_src_inst (
        .clk(clk), .rst_b(rst_b), .req(req), .num(num),
        .sysref(sysref_in), .busy(busy));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task end_sim;
        if (num_errors == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %h not %h", $time, got, exp);
        end
    endtask

    task tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask

    task wr(input logic [15:0] a, input logic [7:0] d);
        tick(1);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        tick(1);
        reg_wr = 1'b0;
    endtask

    task rdc(input logic [15:0] a, input logic [7:0] e);
        tick(1);
        reg_addr = a;
        reg_rd = 1'b1;
        tick(1);
        reg_rd = 1'b0;
        tick(1);
        chk(16'(reg_rdata), 16'(e));
    endtask

    task pulses(input int n);
        int k;
        req = 1'b1;
        num = n[9:0];
        tick(1);
        req = 1'b0;
        for (k = 0; k < 5000 && busy === 1'b1; k++)
            tick(1);
        tick(3);
    endtask

    // Event monitor; also cuts a hang short
    always @(posedge clk) begin
        cyc++;
        if (sysref_in && !sr_prev)
            e_cyc = cyc;
        if (timestamp_mark)
            ts_cyc = cyc;
        dr_n += divider_reset;
        li_n += link_interrupt;
        ms_n += monitor_sync;
        sr_prev = sysref_in;
        if (cyc > 20000) begin
            num_errors++;
            end_sim();
        end
    end

    initial begin
        {rst_b, reg_wr, reg_rd, req, sr_prev} = 5'h00;
        {reg_addr, reg_wdata, num} = 34'h0;
        {div_phase_in, setup_win_in, hold_win_in} = 12'h000;
        fine_mag = 13'h0000;
        sample_in = 14'h0000;
        {num_errors, samples_checked, cyc, e_cyc, ts_cyc} = '0;
        {dr_n, li_n, ms_n} = '0;
        tick(16);
        rst_b = 1'b1;
        for (i = 0; i < 18; i++)
            rdc(TBL[i][39:24], TBL[i][23:16]);
        for (i = 0; i < 18; i++) begin
            wr(TBL[i][39:24], TBL[i][15:8]);
            rdc(TBL[i][39:24], TBL[i][7:0]);
        end
        chk(16'(level_flag_pin), 16'h1);
        chk(16'(peak_detect_en), 16'h1);
        chk(16'(q_ignore), 16'h1);
        for (i = 0; i < 5; i++) begin
            wr(`SSFD_ADDR_APP_MODE, {4'h0, MODES[i*4+:4]});
            chk(16'(app_mode), 16'(MODES[i*4+:4]));
            chk(16'(q_ignore), 16'h0);
            wr(`SSFD_ADDR_DECIMATION, 8'(i));
            chk(16'(decim_factor), 16'h1 << i);
        end
        wr(`SSFD_ADDR_OFFSET, 8'h80);
        sample_in = 14'h0064;
        tick(1);
        chk(16'(sample_out), 16'h3FE4);
        wr(`SSFD_ADDR_OFFSET, 8'h7F);
        sample_in = 14'h1FFF;
        tick(1);
        chk(16'(sample_out), 16'h1FFF);
        wr(`SSFD_ADDR_UPPER_LOW, 8'h64);
        wr(`SSFD_ADDR_UPPER_HIGH, 8'h10);
        wr(`SSFD_ADDR_LOWER_LOW, 8'h32);
        wr(`SSFD_ADDR_LOWER_HIGH, 8'h00);
        wr(`SSFD_ADDR_DWELL_LOW, 8'h02);
        wr(`SSFD_ADDR_DWELL_HIGH, 8'h00);
        wr(`SSFD_ADDR_FLAG_CTRL, 8'h01);
        fine_mag = 13'h1064;
        tick(3);
        chk(16'(level_flag_pin), 16'h0);
        fine_mag = 13'h1065;
        tick(1);
        chk(16'(level_flag_pin), 16'h1);
        fine_mag = 13'h0032;
        tick(6);
        chk(16'(level_flag_pin), 16'h1);
        fine_mag = 13'h0031;
        tick(2);
        chk(16'(level_flag_pin), 16'h1);
        tick(1);
        chk(16'(level_flag_pin), 16'h0);
        wr(`SSFD_ADDR_FLAG_CTRL, 8'h00);
        fine_mag = 13'h1FFF;
        tick(2);
        chk(16'(level_flag_pin), 16'h0);
        wr(`SSFD_ADDR_FLAG_CTRL, 8'h0C);
        chk(16'(level_flag_pin), 16'h1);
        wr(`SSFD_ADDR_FLAG_CTRL, 8'h08);
        chk(16'(level_flag_pin), 16'h0);
        fine_mag = 13'h0000;
        {div_phase_in, setup_win_in, hold_win_in} = 12'h35A;
        wr(`SSFD_ADDR_SYNC_MODE, 8'h00);
        wr(`SSFD_ADDR_SYSREF_CTRL, 8'h02);
        wr(`SSFD_ADDR_MON_SYNC, 8'h01);
        {dr_n, li_n, ms_n} = '0;
        pulses(3);
        wr(`SSFD_ADDR_SYSREF_CTRL, 8'h00);
        rdc(`SSFD_ADDR_CAPTURE_COUNT, 8'h03);
        rdc(`SSFD_ADDR_DIV_PHASE, 8'h03);
        rdc(`SSFD_ADDR_SETUP_HOLD, 8'hA5);
        rdc(`SSFD_ADDR_MON_SYNC, 8'h00);
        chk(16'(dr_n), 16'h3);
        chk(16'(li_n), 16'h3);
        chk(16'(ms_n), 16'h1);
        wr(`SSFD_ADDR_SYSREF_CTRL, 8'h40);
        rdc(`SSFD_ADDR_CAPTURE_COUNT, 8'h00);
        rdc(`SSFD_ADDR_SETUP_HOLD, 8'h00);
        wr(`SSFD_ADDR_SYSREF_CTRL, 8'h02);
        wr(`SSFD_ADDR_SYSREF_CTRL, 8'h12);
        rdc(`SSFD_ADDR_SYSREF_CTRL, 8'h02);
        div_phase_in = 4'h0;
        {dr_n, li_n} = '0;
        pulses(257);
        wr(`SSFD_ADDR_SYSREF_CTRL, 8'h00);
        rdc(`SSFD_ADDR_CAPTURE_COUNT, 8'h01);
        chk(16'(dr_n), 16'd257);
        chk(16'(li_n), 16'h0);
        for (i = 0; i < 3; i++) begin
            j = (i == 2) ? 15 : i * 2;
            wr(`SSFD_ADDR_SYSREF_CTRL, 8'h40);
            wr(`SSFD_ADDR_IGNORE_COUNT, 8'(j));
            wr(`SSFD_ADDR_SYSREF_CTRL, 8'h04);
            dr_n = 0;
            pulses(j);
            chk(16'(dr_n), 16'h0);
            pulses(1);
            chk(16'(dr_n), 16'h1);
            pulses(1);
            chk(16'(dr_n), 16'h1);
        end
        wr(`SSFD_ADDR_SYNC_MODE, 8'h01);
        for (i = 0; i < 2; i++) begin
            wr(`SSFD_ADDR_TS_DELAY, TWO_D[i*8+:8]);
            wr(`SSFD_ADDR_SYSREF_CTRL, 8'h0A);
            chk(16'(capture_edge_fall), 16'h1);
            {dr_n, ts_cyc} = '0;
            pulses(1);
            tick(130);
            chk(16'(ts_cyc - e_cyc), 16'(TWO_D[i*8+:8]) + 16'h2);
            chk(16'(dr_n), 16'h0);
            wr(`SSFD_ADDR_SYSREF_CTRL, 8'h00);
        end
        end_sim();
    end
endmodule
